/* File: verilog/moat_core.v */
// management request dispatch, completion status and supervision timers
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
`include "moat_consts.vh"

module moat_core #(
  parameter TICK_CYCLES = `MOAT_TICK_CYCLES,
  parameter LEN_W       = 21
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // management and stream requests
  input  wire             req_valid_i,
  input  wire             req_stream_i,
  input  wire [3:0]       req_func_i,
  input  wire [2:0]       login_res_req_i,
  input  wire [7:0]       login_alv_req_i,
  output reg              mgmt_done_o,
  output reg  [1:0]       mgmt_resp_o,
  output reg  [7:0]       mgmt_status_o,
  output reg  [2:0]       login_res_code_o,
  output reg  [7:0]       login_alv_sec_o,
  // task actions
  output reg              abort_task_o,
  output reg              abort_set_o,
  output reg              lu_reset_o,
  output reg              tgt_reset_o,
  output reg              release_o,
  // bus and initiator events
  input  wire             bus_reset_i,
  input  wire             doorbell_wr_i,
  input  wire             list_addr_wr_i,
  input  wire             credit_grant_i,
  // command completion
  input  wire             cmd_done_i,
  input  wire [LEN_W-1:0] cmd_bytes_i,
  output reg              sts_valid_o,
  output reg  [1:0]       sts_fmt_o,
  output reg              sts_data_available_flag_o,
  output reg  [LEN_W-1:0] sts_valid_len_o
);

  // session states
  localparam [1:0] SES_IDLE   = 2'b00;
  localparam [1:0] SES_ACTIVE = 2'b01;
  localparam [1:0] SES_RESUME = 2'b10;
  // divider end count, cut to the counter width on purpose
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [27:0] TICK_LAST = TICK_LAST_I[27:0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [31:0]      ctrl_ff;
  reg             data_avail_ff;
  reg [27:0]      tick_cnt_ff;
  reg             tick_ff;
  reg [1:0]       ses_ff;
  reg [2:0]       neg_res_ff;
  reg [7:0]       neg_alv_ff;
  reg [8:0]       res_cnt_ff;
  reg [7:0]       alv_cnt_ff;
  reg             ping_wait_ff;
  reg             credit_ff;
  reg             ping_req_ff;
  reg [3:0]       last_fn_ff;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  wire [2:0] max_res    = ctrl_ff[`MOAT_CTRL_RES_HI:`MOAT_CTRL_RES_LO];
  wire [7:0] max_alv    = ctrl_ff[`MOAT_CTRL_ALV_HI:`MOAT_CTRL_ALV_LO];
  wire       iso_on     = ctrl_ff[`MOAT_CTRL_ISO];
  wire       activity   = doorbell_wr_i | list_addr_wr_i | credit_grant_i;
  wire       wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       mgmt_req   = req_valid_i & ~req_stream_i;
  reg  [2:0] nxt_res;
  reg  [7:0] nxt_alv;
  reg  [8:0] res_limit;
  // zero alive seconds counts as one; either expires on the first tick without activity
  wire [7:0] alv_limit  = (neg_alv_ff == 8'h00) ? 8'h01 : neg_alv_ff;
  // each timer fires on the tick that reaches its limit
  wire       res_expire = tick_ff & (ses_ff == SES_RESUME) &
                          (res_cnt_ff + 9'h001 >= res_limit);
  wire       alv_expire = tick_ff & (ses_ff == SES_ACTIVE) & ~activity &
                          (alv_cnt_ff + 8'h01 >= alv_limit);
  // keepalive leaving now: clears the ping request and uses up the credit
  wire       unsol_sent = sts_valid_o & (sts_fmt_o == `MOAT_FMT_UNSOL);

  // login negotiation: smaller of request and offer
  // isochronous support pins the code to the one second default
  always @* begin
    if (iso_on) begin
      nxt_res = 3'h0;
    end else if (login_res_req_i < max_res) begin
      nxt_res = login_res_req_i;
    end else begin
      nxt_res = max_res;
    end
    if (login_alv_req_i < max_alv) begin
      nxt_alv = login_alv_req_i;
    end else begin
      nxt_alv = max_alv;
    end
  end

  // resumption code lookup
  // whole seconds, five minutes at the top code
  always @* begin
    case (neg_res_ff)
      3'h0: res_limit = `MOAT_RES_SEC_0;
      3'h1: res_limit = `MOAT_RES_SEC_1;
      3'h2: res_limit = `MOAT_RES_SEC_2;
      3'h3: res_limit = `MOAT_RES_SEC_3;
      3'h4: res_limit = `MOAT_RES_SEC_4;
      3'h5: res_limit = `MOAT_RES_SEC_5;
      3'h6: res_limit = `MOAT_RES_SEC_6;
      default: res_limit = `MOAT_RES_SEC_7;
    endcase
  end

  // ---------------------------------------------------------------
  // wishbone slave, one wait cycle per access
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
      ctrl_ff       <= `MOAT_CTRL_RST;
      data_avail_ff <= 1'b0;
    end else begin
      // ack follows the taking edge; read data stands with it one cycle
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      // writes land on the taking edge; status and timer words are read only
      if (wb_req & wb_we_i) begin
        // upper half of ctrl is reserved and reads as zero
        if (wb_adr_i == `MOAT_ADR_CTRL) begin
          if (wb_sel_i[0]) begin
            ctrl_ff[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            ctrl_ff[15:8] <= wb_dat_i[15:8];
          end
        end else if (wb_adr_i == `MOAT_ADR_DATA) begin
          if (wb_sel_i[0]) begin
            data_avail_ff <= wb_dat_i[0];
          end
        end
      end else if (wb_req) begin
        if (wb_adr_i == `MOAT_ADR_CTRL) begin
          wb_dat_o <= {16'h0000, ctrl_ff[15:0]};
        end else if (wb_adr_i == `MOAT_ADR_STAT) begin
          // status word, low to high: session, ping wait, credit, code, function
          wb_dat_o <= {20'h00000,
                       last_fn_ff,
                       1'b0,
                       neg_res_ff,
                       credit_ff,
                       ping_wait_ff,
                       ses_ff};
        end else if (wb_adr_i == `MOAT_ADR_TIMERS) begin
          // timer word: negotiated alive, alive count, release count
          wb_dat_o <= {neg_alv_ff,
                       alv_cnt_ff,
                       7'h00,
                       res_cnt_ff};
        end else if (wb_adr_i == `MOAT_ADR_DATA) begin
          wb_dat_o <= {31'h00000000, data_avail_ff};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // one second tick
  // ---------------------------------------------------------------
  // free running phase, so timers are good to one second
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 28'h0000000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= TICK_LAST) begin
      tick_cnt_ff <= 28'h0000000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 28'h0000001;
      tick_ff     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // management dispatch and session state
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_done_o      <= 1'b0;
      mgmt_resp_o      <= `MOAT_RESP_COMPLETE;
      mgmt_status_o    <= `MOAT_ST_OK;
      login_res_code_o <= 3'h0;
      login_alv_sec_o  <= 8'h00;
      abort_task_o     <= 1'b0;
      abort_set_o      <= 1'b0;
      lu_reset_o       <= 1'b0;
      tgt_reset_o      <= 1'b0;
      release_o        <= 1'b0;
      ses_ff           <= SES_IDLE;
      neg_res_ff       <= 3'h0;
      neg_alv_ff       <= 8'h00;
      res_cnt_ff       <= 9'h000;
      alv_cnt_ff       <= 8'h00;
      ping_wait_ff     <= 1'b0;
      ping_req_ff      <= 1'b0;
      last_fn_ff       <= 4'h0;
    end else begin
      // done follows every request; action outputs are one-cycle pulses
      mgmt_done_o  <= req_valid_i;
      mgmt_resp_o  <= `MOAT_RESP_COMPLETE;
      abort_task_o <= 1'b0;
      abort_set_o  <= 1'b0;
      lu_reset_o   <= 1'b0;
      tgt_reset_o  <= 1'b0;
      release_o    <= 1'b0;
      // the ping request drops once its message is out
      if (unsol_sent) begin
        ping_req_ff <= 1'b0;
      end
      // stream requests always refused
      if (req_valid_i & req_stream_i) begin
        mgmt_status_o <= `MOAT_ST_NOT_SUPP;
      end
      // release timer: runs from first bus reset, never paused
      // a bus reset in resume state is ignored: the deadline is absolute
      if (ses_ff == SES_ACTIVE && bus_reset_i) begin
        ses_ff     <= SES_RESUME;
        res_cnt_ff <= 9'h000;
      end else if (res_expire) begin
        ses_ff     <= SES_IDLE;
        res_cnt_ff <= 9'h000;
        release_o  <= 1'b1;
      end else if (ses_ff == SES_RESUME && tick_ff) begin
        res_cnt_ff <= res_cnt_ff + 9'h001;
      end
      // alive timer supervision
      // activity wins over an expiry in the same cycle
      if (ses_ff == SES_ACTIVE) begin
        if (activity) begin
          alv_cnt_ff   <= 8'h00;
          ping_wait_ff <= 1'b0;
        end else if (alv_expire) begin
          alv_cnt_ff <= 8'h00;
          // ping unanswered, or no credit to ping with: give up
          if (ping_wait_ff | ~credit_ff) begin
            ses_ff       <= SES_IDLE;
            ping_wait_ff <= 1'b0;
            release_o    <= 1'b1;
          end else begin
            ping_req_ff  <= 1'b1;
            ping_wait_ff <= 1'b1;
          end
        end else if (tick_ff) begin
          alv_cnt_ff <= alv_cnt_ff + 8'h01;
        end
      end else begin
        alv_cnt_ff   <= 8'h00;
        ping_wait_ff <= 1'b0;
      end
      // function dispatch
      // login is always taken; validation sits outside this block
      if (mgmt_req) begin
        last_fn_ff    <= req_func_i;
        mgmt_status_o <= `MOAT_ST_OK;
        case (req_func_i)
          `MOAT_FN_LOGIN: begin
            ses_ff           <= SES_ACTIVE;
            neg_res_ff       <= nxt_res;
            neg_alv_ff       <= nxt_alv;
            login_res_code_o <= nxt_res;
            login_alv_sec_o  <= nxt_alv;
            res_cnt_ff       <= 9'h000;
            alv_cnt_ff       <= 8'h00;
          end
          `MOAT_FN_RECONNECT: begin
            // outside the resume window a reconnect has no effect
            if (ses_ff == SES_RESUME && !res_expire) begin
              ses_ff     <= SES_ACTIVE;
              res_cnt_ff <= 9'h000;
              alv_cnt_ff <= 8'h00;
            end
          end
          `MOAT_FN_LOGOUT: begin
            // explicit logout frees the session at once
            ses_ff     <= SES_IDLE;
            res_cnt_ff <= 9'h000;
            release_o  <= 1'b1;
          end
          `MOAT_FN_ABORT: begin
            abort_task_o <= 1'b1;
          end
          `MOAT_FN_ABORT_SET: begin
            abort_set_o <= 1'b1;
          end
          `MOAT_FN_LU_RESET: begin
            lu_reset_o <= 1'b1;
          end
          `MOAT_FN_TGT_RESET: begin
            // target reset drops the session too
            tgt_reset_o <= 1'b1;
            ses_ff      <= SES_IDLE;
            res_cnt_ff  <= 9'h000;
            release_o   <= 1'b1;
          end
          `MOAT_FN_STREAM, `MOAT_FN_PASSWORD, `MOAT_FN_CLEAR_SET: begin
            mgmt_status_o <= `MOAT_ST_NOT_SUPP;
          end
          default: begin
            mgmt_status_o <= `MOAT_ST_OK; // query and reserved codes
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // unsolicited status credit, a grant wins over consumption
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      credit_ff <= 1'b0;
    end else if (credit_grant_i) begin
      credit_ff <= 1'b1;
    end else if (ses_ff == SES_IDLE) begin
      credit_ff <= 1'b0; // a new login starts without credit
    end else if (unsol_sent) begin
      credit_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // completion and unsolicited status words
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sts_valid_o               <= 1'b0;
      sts_fmt_o                 <= `MOAT_FMT_NORMAL;
      sts_data_available_flag_o <= 1'b0;
      sts_valid_len_o           <= {LEN_W{1'b0}};
    end else if (cmd_done_i) begin
      // a completion wins over a pending ping, which waits
      sts_valid_o               <= 1'b1;
      sts_fmt_o                 <= `MOAT_FMT_NORMAL;
      sts_data_available_flag_o <= data_avail_ff;
      sts_valid_len_o           <= cmd_bytes_i;
    end else if (ping_req_ff & ~unsol_sent) begin
      // keepalive carries no new status and a zero length
      sts_valid_o               <= 1'b1;
      sts_fmt_o                 <= `MOAT_FMT_UNSOL;
      sts_data_available_flag_o <= data_avail_ff; // current static state
      sts_valid_len_o           <= {LEN_W{1'b0}};
    end else begin
      sts_valid_o <= 1'b0;
    end
  end

endmodule // moat_core
`default_nettype wire

/* File: verilog/moat_consts.vh */
// constants for the management request and supervision timer block
`ifndef MOAT_CONSTS_VH
`define MOAT_CONSTS_VH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MOAT_CLK_PERIOD_NS   4
`define MOAT_SEC_NS          1000000000
`define MOAT_TICK_CYCLES     (`MOAT_SEC_NS / `MOAT_CLK_PERIOD_NS)
// ---------------------------------------------------------------
// register byte offsets and reset values
// ---------------------------------------------------------------
`define MOAT_ADR_CTRL        8'h00
`define MOAT_ADR_STAT        8'h04
`define MOAT_ADR_TIMERS      8'h08
`define MOAT_ADR_DATA        8'h0C
`define MOAT_CTRL_RST        32'h00003C70
// ctrl fields
`define MOAT_CTRL_ISO        1
`define MOAT_CTRL_RES_LO     4
`define MOAT_CTRL_RES_HI     6
`define MOAT_CTRL_ALV_LO     8
`define MOAT_CTRL_ALV_HI     15
// ---------------------------------------------------------------
// management function codes and answers
// ---------------------------------------------------------------
`define MOAT_FN_LOGIN        4'h0
`define MOAT_FN_QUERY        4'h1
`define MOAT_FN_STREAM       4'h2
`define MOAT_FN_RECONNECT    4'h3
`define MOAT_FN_PASSWORD     4'h4
`define MOAT_FN_RSV5         4'h5
`define MOAT_FN_RSV6         4'h6
`define MOAT_FN_LOGOUT       4'h7
`define MOAT_FN_RSV8         4'h8
`define MOAT_FN_RSV9         4'h9
`define MOAT_FN_RSVA         4'hA
`define MOAT_FN_ABORT        4'hB
`define MOAT_FN_ABORT_SET    4'hC
`define MOAT_FN_CLEAR_SET    4'hD
`define MOAT_FN_LU_RESET     4'hE
`define MOAT_FN_TGT_RESET    4'hF
`define MOAT_RESP_COMPLETE   2'h0
`define MOAT_ST_OK           8'h00
`define MOAT_ST_NOT_SUPP     8'h01
`define MOAT_FMT_NORMAL      2'h0
`define MOAT_FMT_UNSOL       2'h3
// ---------------------------------------------------------------
// resumption code to seconds
// ---------------------------------------------------------------
`define MOAT_RES_SEC_0       9'h001
`define MOAT_RES_SEC_1       9'h005
`define MOAT_RES_SEC_2       9'h00A
`define MOAT_RES_SEC_3       9'h00F
`define MOAT_RES_SEC_4       9'h01E
`define MOAT_RES_SEC_5       9'h03C
`define MOAT_RES_SEC_6       9'h078
`define MOAT_RES_SEC_7       9'h12C
`endif

/* File: tb/moat_core_properties.sv */
// concurrent checks on the ports of the management and timer block
`default_nettype none
module moat_core_properties #(
  parameter TICK_CYCLES = 10,
  parameter LEN_W       = 21
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // requests and completions in
  input wire logic             req_valid_i,
  input wire logic             req_stream_i,
  input wire logic [3:0]       req_func_i,
  input wire logic [7:0]       login_alv_req_i,
  input wire logic             cmd_done_i,
  input wire logic [LEN_W-1:0] cmd_bytes_i,
  // answers out
  input wire logic             mgmt_done_o,
  input wire logic [1:0]       mgmt_resp_o,
  input wire logic [7:0]       mgmt_status_o,
  input wire logic [7:0]       login_alv_sec_o,
  input wire logic             abort_task_o,
  input wire logic             tgt_reset_o,
  input wire logic             sts_valid_o,
  input wire logic [1:0]       sts_fmt_o,
  input wire logic [LEN_W-1:0] sts_valid_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic unsupp;
  // one domain for every check
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // requests answered with not supported
  assign unsupp = req_stream_i || req_func_i == 4'h2 || req_func_i == 4'h4 || req_func_i == 4'hD;
  done_pulse_a:
    assert property (req_valid_i |=> mgmt_done_o ##1 (!mgmt_done_o || $past(req_valid_i)))
    else $error("completion missing or too long");
  stream_refused_a:
    assert property (req_valid_i && req_stream_i |=> mgmt_status_o == 8'h01 && mgmt_resp_o == 2'h0)
    else $error("stream request not refused");
  unsupp_codes_a:
    assert property (req_valid_i && unsupp |=> mgmt_status_o == 8'h01)
    else $error("unsupported code not refused");
  full_codes_a:
    assert property (req_valid_i && !unsupp |=> mgmt_status_o == 8'h00)
    else $error("supported code refused");
  abort_cause_a:
    assert property (abort_task_o |-> $past(req_valid_i && !req_stream_i && req_func_i == 4'hB))
    else $error("abort pulse without abort request");
  tgt_reset_a:
    assert property (req_valid_i && !req_stream_i && req_func_i == 4'hF |=> tgt_reset_o)
    else $error("target reset not issued");
  alive_min_a:
    assert property (req_valid_i && !req_stream_i && req_func_i == 4'h0 && login_alv_req_i != 8'h00
      |=> login_alv_sec_o == ($past(login_alv_req_i) < 8'h3C ? $past(login_alv_req_i) : 8'h3C))
    else $error("alive timeout not the smaller value");
  sts_len_a:
    assert property (cmd_done_i |=> sts_valid_o && sts_fmt_o == 2'h0
      && sts_valid_len_o == $past(cmd_bytes_i))
    else $error("completion status wrong");
  unsol_fmt_a:
    assert property (sts_valid_o && !$past(cmd_done_i) |-> sts_fmt_o == 2'h3)
    else $error("unsolicited status format wrong");
endmodule // moat_core_properties
`default_nettype wire

/* File: tb/moat_host_model.sv */
// host initiator model: task list activity and status credit
`default_nettype none
module moat_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // commands from the bench
  input  wire logic keep_en_i,
  input  wire logic credit_req_i,
  // activity seen by the target
  output var  logic doorbell_wr_o,
  output var  logic list_addr_wr_o,
  output var  logic credit_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  // doorbell and list address writes in turn while enabled
  always @(posedge clk_i) begin
    cnt_ff <= rst_i ? 3'h0 : cnt_ff + 3'h1;
    doorbell_wr_o <= !rst_i && keep_en_i && cnt_ff == 3'h3;
    list_addr_wr_o <= !rst_i && keep_en_i && cnt_ff == 3'h7;
    credit_grant_o <= !rst_i && credit_req_i;
  end
endmodule // moat_host_model
`default_nettype wire

/* File: tb/moat_core_tb_top.sv */
// self-checking bench for the management and timer block
`default_nettype none
bind moat_core moat_core_properties #(.TICK_CYCLES(TICK_CYCLES), .LEN_W(LEN_W)) moat_props_inst (
  .clk_i, .rst_i, .req_valid_i, .req_stream_i, .req_func_i, .login_alv_req_i, .cmd_done_i,
  .cmd_bytes_i, .mgmt_done_o, .mgmt_resp_o, .mgmt_status_o, .login_alv_sec_o, .abort_task_o,
  .tgt_reset_o, .sts_valid_o, .sts_fmt_o, .sts_valid_len_o);
module moat_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid_i, req_stream_i;
  logic        mgmt_done_o, abort_task_o, abort_set_o, lu_reset_o, tgt_reset_o, release_o;
  logic        bus_reset_i, cmd_done_i, sts_valid_o, sts_data_available_flag_o;
  logic        doorbell_wr_i, list_addr_wr_i, credit_grant_i, keep_en, credit_req;
  logic [1:0]  mgmt_resp_o, sts_fmt_o;
  logic [2:0]  login_res_req_i, login_res_code_o;
  logic [3:0]  wb_sel_i, req_func_i;
  logic [7:0]  wb_adr_i, login_alv_req_i, mgmt_status_o, login_alv_sec_o;
  logic [20:0] cmd_bytes_i, sts_valid_len_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          errors, n_compared, n_rel, n_unsol, ncyc, t0, r0, u0;
  moat_core #(.TICK_CYCLES(10), .LEN_W(21)) moat_core_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .req_valid_i, .req_stream_i, .req_func_i, .login_res_req_i, .login_alv_req_i,
    .mgmt_done_o, .mgmt_resp_o, .mgmt_status_o, .login_res_code_o, .login_alv_sec_o,
    .abort_task_o, .abort_set_o, .lu_reset_o, .tgt_reset_o, .release_o, .bus_reset_i,
    .doorbell_wr_i, .list_addr_wr_i, .credit_grant_i, .cmd_done_i, .cmd_bytes_i, .sts_valid_o,
    .sts_fmt_o, .sts_data_available_flag_o, .sts_valid_len_o);
  moat_host_model moat_host_model_inst (.clk_i, .rst_i, .keep_en_i(keep_en),
    .credit_req_i(credit_req), .doorbell_wr_o(doorbell_wr_i), .list_addr_wr_o(list_addr_wr_i),
    .credit_grant_o(credit_grant_i));
  // 250 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // count cycles, releases and keepalive messages
  always @(posedge clk_i) begin
    ncyc <= ncyc + 1;
    if (release_o === 1'h1) n_rel++;
    if (sts_valid_o === 1'h1 && sts_fmt_o === 2'h3) n_unsol++;
  end
  task automatic close_out();
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20) begin
      chk(0, 1);
      close_out();
    end
  endtask
  task automatic req(input logic [3:0] fn, input logic st, input logic [2:0] rc,
                     input logic [7:0] alv);
    @(posedge clk_i);
    req_valid_i <= 1'h1;
    req_func_i <= fn;
    req_stream_i <= st;
    login_res_req_i <= rc;
    login_alv_req_i <= alv;
    @(posedge clk_i);
    req_valid_i <= 1'h0;
    #1;
  endtask
  task automatic wait_n(input bit unsol, input int tgt);
    int n;
    n = 0;
    while ((unsol ? n_unsol : n_rel) < tgt) begin
      @(posedge clk_i);
      #1 n++;
      if (n > 100) begin
        chk(0, 1);
        close_out();
      end
    end
  endtask
  task automatic bus_reset();
    @(posedge clk_i);
    bus_reset_i <= 1'h1;
    @(posedge clk_i);
    bus_reset_i <= 1'h0;
    t0 = ncyc;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs_login();
    wb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h00003C70);
    wb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    req(4'h0, 1'h0, 3'h5, 8'h50);
    chk({login_res_code_o, login_alv_sec_o}, {3'h5, 8'h3C});
    wb(1'h1, 8'h00, 32'h00003C72);
    req(4'h0, 1'h0, 3'h7, 8'h3C);
    chk(login_res_code_o, 3'h0);
    wb(1'h1, 8'h00, 32'h00003C70);
  endtask
  task automatic t_status();
    wb(1'h1, 8'h0C, 32'h1);
    @(posedge clk_i);
    cmd_done_i <= 1'h1;
    cmd_bytes_i <= 21'h100000;
    @(posedge clk_i);
    cmd_bytes_i <= 21'h000003;
    #1 chk({sts_valid_o, sts_fmt_o, sts_data_available_flag_o}, 4'h9);
    chk(sts_valid_len_o, 21'h100000);
    @(posedge clk_i);
    cmd_done_i <= 1'h0;
    #1 chk(sts_valid_len_o, 21'h000003);
    wb(1'h1, 8'h0C, 32'h0);
    @(posedge clk_i);
    cmd_done_i <= 1'h1;
    @(posedge clk_i);
    cmd_done_i <= 1'h0;
    #1 chk({sts_valid_o, sts_data_available_flag_o}, 2'h2);
  endtask
  task automatic t_funcs();
    logic [3:0] act;
    for (int f = 0; f < 16; f++) begin
      act = {f == 11, f == 12, f == 14, f == 15};
      req(f[3:0], 1'h0, 3'h0, 8'h3C);
      chk(mgmt_done_o, 1'h1);
      chk(mgmt_status_o, (f == 2 || f == 4 || f == 13) ? 8'h01 : 8'h00);
      chk({abort_task_o, abort_set_o, lu_reset_o, tgt_reset_o}, act);
    end
    req(4'h0, 1'h1, 3'h0, 8'h3C);
    chk(mgmt_status_o, 8'h01);
  endtask
  task automatic t_release();
    req(4'h0, 1'h0, 3'h1, 8'h3C);
    r0 = n_rel;
    bus_reset();
    repeat (34) @(posedge clk_i);
    bus_reset_i <= 1'h1;
    @(posedge clk_i);
    bus_reset_i <= 1'h0;
    wait_n(1'h0, r0 + 1);
    chk((ncyc - t0) >= 38 && (ncyc - t0) <= 66, 1'h1);
    req(4'h0, 1'h0, 3'h1, 8'h3C);
    r0 = n_rel;
    bus_reset();
    repeat (25) @(posedge clk_i);
    req(4'h3, 1'h0, 3'h0, 8'h3C);
    repeat (100) @(posedge clk_i);
    chk(n_rel - r0, 0);
    wb(1'h0, 8'h08, 32'h0);
    chk(rd[8:0], 9'h000);
    req(4'h7, 1'h0, 3'h0, 8'h3C);
    wait_n(1'h0, r0 + 1);
    chk(n_rel - r0, 1);
  endtask
  task automatic t_alive();
    req(4'h0, 1'h0, 3'h0, 8'h02);
    r0 = n_rel;
    u0 = n_unsol;
    keep_en <= 1'h1;
    repeat (80) @(posedge clk_i);
    chk(n_rel - r0, 0);
    chk(n_unsol - u0, 0);
    keep_en <= 1'h0;
    credit_req <= 1'h1;
    @(posedge clk_i);
    credit_req <= 1'h0;
    t0 = ncyc;
    wait_n(1'h1, u0 + 1);
    chk(ncyc - t0 <= 36, 1'h1);
    t0 = ncyc;
    wait_n(1'h0, r0 + 1);
    chk(ncyc - t0 <= 36, 1'h1);
    req(4'h0, 1'h0, 3'h0, 8'h02);
    wait_n(1'h0, r0 + 2);
    chk(n_unsol - u0, 1);
  endtask
  // reset, then every scenario in turn
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, req_stream_i, bus_reset_i} = 7'h40;
    {cmd_done_i, keep_en, credit_req, req_func_i, login_res_req_i, login_alv_req_i} = 18'h0;
    {wb_adr_i, wb_dat_i, cmd_bytes_i} = 61'h0;
    wb_sel_i = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs_login();
    t_status();
    t_funcs();
    t_release();
    t_alive();
    close_out();
  end
endmodule // moat_core_tb_top
`default_nettype wire
